// ---- src/htm_pkg.sv ----
// constants, types and register map of the humidity threshold monitor
package htm_pkg;
	// clock and time base
	localparam int unsigned CLK_PERIOD_NS = 20;
	localparam int unsigned SEC_NS        = 1000000000;
	localparam int unsigned CYC_PER_SEC   = SEC_NS / CLK_PERIOD_NS;
	localparam int unsigned CYCLE_STEP_S  = 10;
	localparam logic [6:0]  CYCLE_MAX     = 7'h78;

	// register byte offsets
	localparam logic [7:0] OFS_CFG    = 8'h00;
	localparam logic [7:0] OFS_EXT16  = 8'h04;
	localparam logic [7:0] OFS_EXT8   = 8'h08;
	localparam logic [7:0] OFS_TEACH  = 8'h0c;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MEAS   = 8'h14;

	// humidity values are in units of 0.1 g/m3
	localparam logic [15:0] LIM_MIN    = 16'h0064;
	localparam logic [15:0] LIM_MAX    = 16'h0320;
	localparam logic [15:0] HYST_MAX   = 16'h0064;
	localparam logic [15:0] UPPER_RANGE = 16'h0320;

	localparam logic [15:0] LIM_TAB [11] = '{16'h0064, 16'h0096, 16'h00c8, 16'h00fa, 16'h012c, 16'h015e,
		16'h0190, 16'h01f4, 16'h0258, 16'h02bc, 16'h0320};
	localparam logic [15:0] HYST_TAB [6] = '{16'h0000, 16'h0014, 16'h001e, 16'h0032, 16'h0046, 16'h0064};
	// delay choices in seconds
	localparam logic [11:0] DLY_TAB [14] = '{12'h000, 12'h001, 12'h003, 12'h005, 12'h00a, 12'h00f, 12'h01e,
		12'h03c, 12'h0b4, 12'h12c, 12'h258, 12'h384, 12'h708, 12'he10};

	// actions: none, on, off
	localparam logic [1:0] ACT_NONE = 2'h0;
	localparam logic [1:0] ACT_ON   = 2'h1;
	localparam logic [1:0] ACT_OFF  = 2'h2;
	// mode entry {exceed_type, cross action, return action}
	localparam logic [4:0] MODE_TAB [12] = '{5'h16, 5'h19, 5'h06, 5'h09, 5'h14, 5'h18,
		5'h04, 5'h08, 5'h12, 5'h11, 5'h02, 5'h01};

	typedef enum logic [1:0] {EXT_NONE, EXT_16, EXT_8, EXT_TEACH} htm_ext_type;
	typedef enum {ST_IDLE, ST_ON_WAIT, ST_OFF_WAIT} htm_state_type;

	// configuration word, bit 0 at the right
	typedef struct packed {
		logic       rsv1;
		logic [6:0] cycle;
		logic       rsv0;
		logic       send_on_change;
		logic [3:0] off_dly;
		logic [3:0] on_dly;
		logic [1:0] ext_sel;
		logic [3:0] mode;
		logic [2:0] hyst;
		logic [3:0] lim;
	} htm_cfg_type;

	localparam htm_cfg_type CFG_RESET = '0;
endpackage

// ---- src/htm_monitor.sv ----
// humidity threshold monitor: limit compare, action table, delays and sending
`timescale 1ns/10ps
module htm_monitor #(
	parameter int unsigned CYC_PER_SEC = htm_pkg::CYC_PER_SEC
) (
	input  wire logic        clk_i,
	input  wire logic        sys_rst_i,
	input  wire logic        ce_i,
	input  wire logic [15:0] meas_i,
	input  wire logic [7:0]  addr_i,
	input  wire logic [31:0] wdata_i,
	input  wire logic        wr_i,
	input  wire logic        rd_i,
	output logic      [31:0] rdata_o,
	output logic             limit_state_o,
	output logic             tx_o,
	output logic             tx_value_o
);
	htm_pkg::htm_cfg_type   cfg_q;
	htm_pkg::htm_state_type state_q;
	logic [15:0] ext_lim_q;
	logic        ext_valid_q;
	logic [25:0] pre_q;
	logic        tick_q;
	logic        cond_q;
	logic        raw_q;
	logic        out_q;
	logic        out_prev_q;
	logic [11:0] dly_q;
	logic [11:0] cyc_q;
	logic        chg_send_q;
	logic        cyc_send_q;
	logic [31:0] rdata_q;
	logic        cfg_wr;
	logic        teach_wr;
	logic [15:0] cfg_lim;
	logic [15:0] hyst_val;
	logic [15:0] lim_w;
	logic [16:0] lim_hi;
	logic [16:0] lim_lo;
	logic [4:0]  mode_ent;
	logic [1:0]  act_cross;
	logic [1:0]  act_ret;
	logic        set_w;
	logic        clr_w;
	logic        supp_w;
	logic [11:0] on_dly_s;
	logic [11:0] off_dly_s;
	logic [11:0] cyc_reload;
	logic [23:0] ext8_scaled;

	assign cfg_wr   = wr_i && (addr_i == htm_pkg::OFS_CFG);
	assign teach_wr = wr_i && (addr_i == htm_pkg::OFS_TEACH);

	// table lookups, out-of-range selections fall back to the first entry
	always_comb begin
		cfg_lim   = (cfg_q.lim < 4'hb) ? htm_pkg::LIM_TAB[cfg_q.lim] : htm_pkg::LIM_TAB[0];
		hyst_val  = (cfg_q.hyst < 3'h6) ? htm_pkg::HYST_TAB[cfg_q.hyst] : htm_pkg::HYST_TAB[0];
		mode_ent  = (cfg_q.mode < 4'hc) ? htm_pkg::MODE_TAB[cfg_q.mode] : htm_pkg::MODE_TAB[0];
		on_dly_s  = (cfg_q.on_dly < 4'he) ? htm_pkg::DLY_TAB[cfg_q.on_dly] : htm_pkg::DLY_TAB[0];
		off_dly_s = (cfg_q.off_dly < 4'he) ? htm_pkg::DLY_TAB[cfg_q.off_dly] : htm_pkg::DLY_TAB[0];
	end

	assign act_cross = mode_ent[3:2];
	assign act_ret   = mode_ent[1:0];
	// period in seconds, settings above the top step are clamped
	assign cyc_reload = ((cfg_q.cycle > htm_pkg::CYCLE_MAX) ? 12'(htm_pkg::CYCLE_MAX) : 12'(cfg_q.cycle))
		* 12'(htm_pkg::CYCLE_STEP_S);

	// one-byte value is a fraction of the upper range in 256ths, scaled by 1/256 to avoid a divider
	assign ext8_scaled = 24'(wdata_i[7:0]) * 24'(htm_pkg::UPPER_RANGE);

	// external limit only after a fresh value since the last download
	assign lim_w = (cfg_q.ext_sel != htm_pkg::EXT_NONE && ext_valid_q) ? ext_lim_q : cfg_lim;
	assign lim_hi = {1'b0, lim_w} + {1'b0, hyst_val};
	assign lim_lo = (lim_w > hyst_val) ? ({1'b0, lim_w} - {1'b0, hyst_val}) : 17'h00000;

	// crossing detection; strict compares so equality never toggles
	always_comb begin
		if (mode_ent[4]) begin
			set_w = {1'b0, meas_i} > {1'b0, lim_w};
			clr_w = {1'b0, meas_i} < lim_lo;
		end else begin
			set_w = meas_i < lim_w;
			clr_w = {1'b0, meas_i} > lim_hi;
		end
	end

	// cyclic sends are muted while the action of the holding condition is none
	assign supp_w = cond_q ? (act_cross == htm_pkg::ACT_NONE) : (act_ret == htm_pkg::ACT_NONE);

	// configuration write acts as a download
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cfg_q <= htm_pkg::CFG_RESET;
		end else if (ce_i && cfg_wr) begin
			cfg_q <= htm_pkg::htm_cfg_type'(wdata_i[30:0]); // bit 31 is reserved, word is one bit wider
		end
	end

	// external and taught limit; a download invalidates the held value
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			ext_lim_q   <= 16'h0000;
			ext_valid_q <= 1'b0;
		end else if (ce_i) begin
			if (cfg_wr) begin
				ext_valid_q <= 1'b0;
			end else if (wr_i && addr_i == htm_pkg::OFS_EXT16 && cfg_q.ext_sel == htm_pkg::EXT_16) begin
				ext_lim_q   <= wdata_i[15:0];
				ext_valid_q <= 1'b1;
			end else if (wr_i && addr_i == htm_pkg::OFS_EXT8 && cfg_q.ext_sel == htm_pkg::EXT_8) begin
				ext_lim_q   <= ext8_scaled[23:8];
				ext_valid_q <= 1'b1;
			end else if (teach_wr && cfg_q.ext_sel == htm_pkg::EXT_TEACH) begin
				ext_lim_q   <= meas_i;
				ext_valid_q <= 1'b1;
			end
		end
	end

	// seconds time base
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			pre_q  <= 26'h0000000;
			tick_q <= 1'b0;
		end else if (ce_i) begin
			tick_q <= 1'b0;
			if (pre_q >= 26'(CYC_PER_SEC - 1)) begin
				pre_q  <= 26'h0000000;
				tick_q <= 1'b1;
			end else begin
				pre_q <= pre_q + 26'h0000001;
			end
		end
	end

	// hysteresis state and raw limit state from the action table
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cond_q <= 1'b0;
			raw_q  <= 1'b0;
		end else if (ce_i) begin
			if (!cond_q && set_w) begin
				cond_q <= 1'b1;
				if (act_cross == htm_pkg::ACT_ON) begin
					raw_q <= 1'b1;
				end else if (act_cross == htm_pkg::ACT_OFF) begin
					raw_q <= 1'b0;
				end
			end else if (cond_q && clr_w) begin
				cond_q <= 1'b0;
				if (act_ret == htm_pkg::ACT_ON) begin
					raw_q <= 1'b1;
				end else if (act_ret == htm_pkg::ACT_OFF) begin
					raw_q <= 1'b0;
				end
			end
		end
	end

	// switch-on/off delays; timer counts whole ticks so first second may be short
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			state_q <= htm_pkg::ST_IDLE;
			dly_q   <= 12'h000;
			out_q   <= 1'b0;
		end else if (ce_i) begin
			case (state_q)
				htm_pkg::ST_IDLE: begin
					if (raw_q && !out_q) begin
						if (on_dly_s == 12'h000) begin
							out_q <= 1'b1;
						end else begin
							dly_q   <= on_dly_s;
							state_q <= htm_pkg::ST_ON_WAIT;
						end
					end else if (!raw_q && out_q) begin
						if (off_dly_s == 12'h000) begin
							out_q <= 1'b0;
						end else begin
							dly_q   <= off_dly_s;
							state_q <= htm_pkg::ST_OFF_WAIT;
						end
					end
				end
				htm_pkg::ST_ON_WAIT, htm_pkg::ST_OFF_WAIT: begin
					if (raw_q == out_q) begin
						state_q <= htm_pkg::ST_IDLE;
					end else if (tick_q) begin
						if (dly_q == 12'h001) begin
							out_q   <= raw_q;
							state_q <= htm_pkg::ST_IDLE;
						end else begin
							dly_q <= dly_q - 12'h001;
						end
					end
				end
				default: begin
					state_q <= htm_pkg::ST_IDLE;
				end
			endcase
		end
	end

	// send on change of the delayed state
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			out_prev_q <= 1'b0;
			chg_send_q <= 1'b0;
		end else if (ce_i) begin
			out_prev_q <= out_q;
			chg_send_q <= (out_q != out_prev_q) && cfg_q.send_on_change;
		end
	end

	// cyclic repeat; counter reloads so a new setting takes effect within one period
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			cyc_q      <= 12'h000;
			cyc_send_q <= 1'b0;
		end else if (ce_i) begin
			cyc_send_q <= 1'b0;
			if (cfg_q.cycle == 7'h00) begin
				cyc_q <= 12'h000;
			end else if (cyc_q == 12'h000 || cyc_q > cyc_reload) begin
				cyc_q <= cyc_reload;
			end else if (tick_q) begin
				if (cyc_q == 12'h001) begin
					cyc_q      <= cyc_reload;
					cyc_send_q <= !supp_w;
				end else begin
					cyc_q <= cyc_q - 12'h001;
				end
			end
		end
	end

	// read port, data valid only in the cycle after the strobe
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			rdata_q <= 32'h00000000;
		end else if (ce_i) begin
			rdata_q <= 32'h00000000;
			if (rd_i) begin
				case (addr_i)
					htm_pkg::OFS_CFG:    rdata_q <= 32'(cfg_q);
					htm_pkg::OFS_EXT16:  rdata_q <= {16'h0000, ext_lim_q};
					htm_pkg::OFS_STATUS: rdata_q <= {lim_w, 8'h00, 1'b0, 2'(state_q), supp_w,
						ext_valid_q, out_q, raw_q, cond_q};
					htm_pkg::OFS_MEAS:   rdata_q <= {16'h0000, meas_i};
					default:             rdata_q <= 32'h00000000;
				endcase
			end
		end
	end

	assign rdata_o       = rdata_q;
	assign limit_state_o = out_q;
	assign tx_value_o    = out_q;
	assign tx_o          = chg_send_q || cyc_send_q;

	// checks
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	hyst_bound_a: assert property (hyst_val <= htm_pkg::HYST_MAX) else $error("hysteresis too large");
	lim_range_a: assert property (cfg_lim >= htm_pkg::LIM_MIN && cfg_lim <= htm_pkg::LIM_MAX)
		else $error("configured limit out of range");
	cross_on_a: assert property (ce_i && !cond_q && set_w && act_cross == htm_pkg::ACT_ON |=> cond_q && raw_q)
		else $error("cross action not applied");
	under_ret_a: assert property (ce_i && cond_q && !mode_ent[4] && meas_i < lim_w |=> cond_q)
		else $error("undershoot returned inside hysteresis");
	ret_none_a: assert property (ce_i && cond_q && clr_w && act_ret == htm_pkg::ACT_NONE |=> $stable(raw_q))
		else $error("none return changed state");
	ext16_take_a: assert property (ce_i && wr_i && addr_i == htm_pkg::OFS_EXT16
		&& cfg_q.ext_sel == htm_pkg::EXT_16 |=> ext_valid_q && ext_lim_q == $past(wdata_i[15:0]))
		else $error("16-bit limit not taken");
	ext8_take_a: assert property (ce_i && wr_i && addr_i == htm_pkg::OFS_EXT8
		&& cfg_q.ext_sel == htm_pkg::EXT_8 |=> ext_valid_q)
		else $error("8-bit limit not taken");
	teach_store_a: assert property (ce_i && teach_wr && cfg_q.ext_sel == htm_pkg::EXT_TEACH
		|=> ext_lim_q == $past(meas_i) && lim_w == ext_lim_q)
		else $error("teaching did not store measurement");
	dl_override_a: assert property (ce_i && cfg_wr |=> !ext_valid_q && lim_w == cfg_lim)
		else $error("download kept external limit");
	on_delay_a: assert property (ce_i && state_q == htm_pkg::ST_IDLE && raw_q && !out_q
		&& on_dly_s != 12'h000 |=> state_q == htm_pkg::ST_ON_WAIT && !out_q)
		else $error("switch-on delay skipped");
	on_wait_zero_a: assert property (state_q == htm_pkg::ST_ON_WAIT |-> !tx_value_o)
		else $error("one reported during switch-on delay");
	off_delay_a: assert property (ce_i && state_q == htm_pkg::ST_IDLE && !raw_q && out_q
		&& off_dly_s != 12'h000 |=> state_q == htm_pkg::ST_OFF_WAIT && out_q)
		else $error("switch-off delay skipped");
	off_wait_one_a: assert property (state_q == htm_pkg::ST_OFF_WAIT |-> tx_value_o)
		else $error("zero reported during switch-off delay");
	cyc_mute_a: assert property (cyc_send_q |-> !$past(supp_w)) else $error("cyclic send while muted");
	no_chg_tx_a: assert property (tx_o && !$past(cfg_q.send_on_change) |-> cyc_send_q)
		else $error("change send while disabled");
	chg_send_a: assert property (ce_i && $changed(out_q) && cfg_q.send_on_change |=> tx_o)
		else $error("state change not sent");
	cyc_period_a: assert property (ce_i && tick_q && cyc_q == 12'h001 && cfg_q.cycle != 7'h00
		&& cfg_q.cycle <= htm_pkg::CYCLE_MAX |=> cyc_q == 12'($past(cfg_q.cycle)) * 12'(htm_pkg::CYCLE_STEP_S))
		else $error("cycle period wrong");
	cyc_off_a: assert property ($past(cfg_q.cycle) == 7'h00 |-> !cyc_send_q)
		else $error("cyclic send with zero setting");
	silent_a: assert property ($past(cfg_q.cycle) == 7'h00 && !$past(cfg_q.send_on_change) |-> !tx_o)
		else $error("send while sending disabled");
	cancel_dly_a: assert property (ce_i && state_q != htm_pkg::ST_IDLE && raw_q == out_q
		|=> state_q == htm_pkg::ST_IDLE && $stable(out_q))
		else $error("revert did not cancel delay");

	on_after_delay_c: cover property (state_q == htm_pkg::ST_ON_WAIT ##1 state_q == htm_pkg::ST_IDLE && out_q);
	cancelled_c: cover property (state_q == htm_pkg::ST_OFF_WAIT && raw_q ##1 state_q == htm_pkg::ST_IDLE);
	cyc_sent_c: cover property (cyc_send_q && tx_value_o);
	taught_c: cover property (teach_wr && ce_i && cfg_q.ext_sel == htm_pkg::EXT_TEACH);
endmodule

// ---- tb/htm_bus_model.sv ----
// bus-side model: counts limit telegrams and keeps the last value sent
`timescale 1ns/10ps
module htm_bus_model (
	input  wire logic clk_i,
	input  wire logic sys_rst_i,
	input  wire logic tx_i,
	input  wire logic tx_value_i,
	output int        tx_cnt_o,
	output logic      last_val_o
);
	// each pulse is one telegram of the one-bit object
	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			tx_cnt_o   <= 0;
			last_val_o <= 1'b0;
		end else if (tx_i) begin
			tx_cnt_o   <= tx_cnt_o + 1;
			last_val_o <= tx_value_i;
		end
	end
endmodule

// ---- tb/tb.sv ----
// self-checking bench of the humidity threshold monitor
`timescale 1ns/10ps
module tb;
	logic        clk_i     = 1'b0;
	logic        sys_rst_i = 1'b1;
	logic        ce_i      = 1'b1;
	logic [15:0] meas_i    = 16'h0000;
	logic [7:0]  addr_i    = 8'h00;
	logic [31:0] wdata_i   = 32'h0;
	logic        wr_i      = 1'b0;
	logic        rd_i      = 1'b0;
	logic [31:0] rdata_o;
	logic        limit_state_o;
	logic        tx_o;
	logic        tx_value_o;
	int          tx_cnt;
	logic        last_val;
	int          bad_count = 0;
	int          compares  = 0;
	int          n;
	logic [31:0] r;

	// 50 MHz clock
	always #10 clk_i = ~clk_i;

	// ten cycles per second keeps the delays short
	htm_monitor #(.CYC_PER_SEC(10)) DUT (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .meas_i(meas_i),
		.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.limit_state_o(limit_state_o), .tx_o(tx_o), .tx_value_o(tx_value_o));
	htm_bus_model u_bus (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .tx_i(tx_o), .tx_value_i(tx_value_o),
		.tx_cnt_o(tx_cnt), .last_val_o(last_val));

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h expected %h", $time, seen, exp);
		end
	endtask

	task end_sim;
		if (bad_count == 0 && compares > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// waits end mid-cycle so outputs have settled
	task cyc(input int k);
		repeat (k) @(posedge clk_i);
		@(negedge clk_i);
	endtask

	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		addr_i  <= a;
		wdata_i <= d;
		wr_i    <= 1'b1;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask

	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_i);
		addr_i <= a;
		rd_i   <= 1'b1;
		@(posedge clk_i);
		rd_i <= 1'b0;
		@(negedge clk_i);
		d = rdata_o;
	endtask

	task meas(input logic [15:0] v, input int k);
		@(posedge clk_i);
		meas_i <= v;
		cyc(k);
	endtask

	// limit index 0 (10 g/m3), same delay for both directions
	function automatic logic [31:0] cf(input logic [2:0] hy, input logic [3:0] md, input logic [1:0] ex,
		input logic [3:0] dl, input logic sc, input logic [6:0] cy);
		htm_pkg::htm_cfg_type c;
		c = htm_pkg::CFG_RESET;
		c.hyst = hy;
		c.mode = md;
		c.ext_sel = ex;
		c.on_dly = dl;
		c.off_dly = dl;
		c.send_on_change = sc;
		c.cycle = cy;
		return 32'(c);
	endfunction

	task t_reset;
		chk({31'h0, limit_state_o}, 32'h0);
		rd(htm_pkg::OFS_CFG, r);
		chk(r, 32'h0);
		wr(htm_pkg::OFS_STATUS, 32'hffffffff);
		rd(8'h20, r);
		chk(r, 32'h0);
		rd(htm_pkg::OFS_STATUS, r);
		chk({16'h0, r[31:16]}, 32'h0064);
	endtask

	task t_change;
		meas(16'h0032, 4);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h0, 4'h0, 1'b1, 7'h00));
		n = tx_cnt;
		meas(16'h0065, 6);
		chk({31'h0, limit_state_o}, 32'h1);
		chk(tx_cnt - n, 32'h1);
		meas(16'h0064, 6);
		chk({31'h0, limit_state_o}, 32'h1);
		meas(16'h0063, 6);
		chk({31'h0, limit_state_o}, 32'h0);
		chk(tx_cnt - n, 32'h2);
		chk({31'h0, last_val}, 32'h0);
	endtask

	// every hysteresis step at a 20 g/m3 limit, so limit-hyst never floors at zero
	task t_hyst;
		for (int i = 0; i < 6; i++) begin
			meas(16'h0032, 4);
			wr(htm_pkg::OFS_CFG, cf(i[2:0], 4'h0, 2'h0, 4'h0, 1'b1, 7'h00) | 32'h00000002);
			meas(16'h00c9, 6);
			meas(16'h00c8 - htm_pkg::HYST_TAB[i], 6);
			chk({31'h0, limit_state_o}, 32'h1);
			meas(16'h00c7 - htm_pkg::HYST_TAB[i], 6);
			chk({31'h0, limit_state_o}, 32'h0);
		end
	endtask

	task step(input logic [15:0] v, input logic [1:0] a);
		n = tx_cnt;
		meas(v, 6);
		if (a == htm_pkg::ACT_NONE) begin
			chk(tx_cnt - n, 32'h0);
		end else begin
			chk({31'h0, limit_state_o}, {31'h0, a == htm_pkg::ACT_ON});
		end
	endtask

	// all twelve direction/action modes, crossing then returning
	task t_modes;
		logic [4:0] e;
		for (int m = 0; m < 12; m++) begin
			e = htm_pkg::MODE_TAB[m];
			meas(e[4] ? 16'h0032 : 16'h0096, 4);
			wr(htm_pkg::OFS_CFG, cf(3'h0, m[3:0], 2'h0, 4'h0, 1'b1, 7'h00));
			// let a leftover crossing and its change telegram drain first
			cyc(6);
			step(e[4] ? 16'h0065 : 16'h0063, e[3:2]);
			step(e[4] ? 16'h0063 : 16'h0065, e[1:0]);
		end
	endtask

	task t_ext;
		meas(16'h0032, 4);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h1, 4'h0, 1'b1, 7'h00));
		wr(htm_pkg::OFS_EXT16, 32'h000000c8);
		rd(htm_pkg::OFS_STATUS, r);
		chk({16'h0, r[31:16]}, 32'h00c8);
		meas(16'h00c9, 6);
		chk({31'h0, limit_state_o}, 32'h1);
		meas(16'h0032, 6);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h1, 4'h0, 1'b1, 7'h00));
		rd(htm_pkg::OFS_STATUS, r);
		chk({16'h0, r[31:16]}, 32'h0064);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h2, 4'h0, 1'b1, 7'h00));
		wr(htm_pkg::OFS_EXT8, 32'h00000080);
		rd(htm_pkg::OFS_STATUS, r);
		chk({16'h0, r[31:16]}, 32'h0190);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h3, 4'h0, 1'b1, 7'h00));
		meas(16'h012c, 2);
		wr(htm_pkg::OFS_TEACH, 32'h0);
		rd(htm_pkg::OFS_STATUS, r);
		chk({16'h0, r[31:16]}, 32'h012c);
	endtask

	// 3 s both ways; first second may be short, so check at 18 and 40 cycles
	task t_delay;
		meas(16'h0032, 4);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h0, 4'h2, 1'b1, 7'h00));
		n = tx_cnt;
		meas(16'h0065, 18);
		chk({31'h0, limit_state_o}, 32'h0);
		cyc(22);
		chk({31'h0, limit_state_o}, 32'h1);
		meas(16'h0032, 18);
		chk({31'h0, limit_state_o}, 32'h1);
		cyc(22);
		chk({31'h0, limit_state_o}, 32'h0);
		meas(16'h0065, 10);
		meas(16'h0032, 40);
		chk({31'h0, limit_state_o}, 32'h0);
		chk(tx_cnt - n, 32'h2);
	endtask

	task t_cyclic;
		meas(16'h0032, 4);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h0, 4'h0, 1'b0, 7'h01));
		n = tx_cnt;
		cyc(350);
		chk(tx_cnt - n, 32'h3);
		chk({31'h0, last_val}, 32'h0);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h0, 2'h0, 4'h0, 1'b0, 7'h00));
		n = tx_cnt;
		meas(16'h0065, 250);
		chk(tx_cnt - n, 32'h0);
		chk({31'h0, limit_state_o}, 32'h1);
		wr(htm_pkg::OFS_CFG, cf(3'h0, 4'h8, 2'h0, 4'h0, 1'b0, 7'h01));
		n = tx_cnt;
		cyc(250);
		chk(tx_cnt - n, 32'h0);
	endtask

	// runs near 1600 cycles; the limit leaves ample margin
	initial begin
		#200000;
		bad_count++;
		end_sim();
	end

	initial begin
		repeat (5) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		cyc(1);
		t_reset();
		t_change();
		t_hyst();
		t_modes();
		t_ext();
		t_delay();
		t_cyclic();
		end_sim();
	end
endmodule
